// ---- ddr_init_ctrl.sv ----
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module ddr_init_ctrl #(
  parameter int PLL_LOCK_CYCLES = ddr_init_pkg::PLL_LOCK_CYC,
  parameter int POWERUP_CYCLES = ddr_init_pkg::POWERUP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Software port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Module command pins and status outputs
  output logic cke,
  output ddr_init_pkg::ddr_cmd_t ddr_cmd,
  output logic init_done,
  output logic read_allowed
);
  localparam int CNT_W = ddr_init_pkg::CNT_W;

  ddr_init_pkg::init_state_t state_reg, state_next;
  logic [ddr_init_pkg::CNT_W-1:0] wait_reg, wait_next;
  logic [7:0] gap_reg;
  logic issued;
  logic [4:0] ctrl_reg;
  logic [12:0] mode_reg;
  logic cke_reg, done_reg;
  ddr_init_pkg::ddr_cmd_t cmd_reg, cmd_next;
  logic [31:0] rdata_reg;
  logic allow_reg;
  // Checker state
  logic [CNT_W-1:0] hold_cnt_reg;
  logic [7:0] since_dll_reg;
  logic [3:0] cmd_count_reg;

  wire wr_ctrl = wr && addr == ddr_init_pkg::ADDR_CTRL;
  wire wr_mode = wr && addr == ddr_init_pkg::ADDR_MODE;
  wire start_req = wr_ctrl && wdata[ddr_init_pkg::CTRL_START_BIT];
  wire dll_req = wr_ctrl && wdata[ddr_init_pkg::CTRL_DLL_RESET_BIT];
  wire waiting = wait_reg != '0;
  wire read_ok = gap_reg == 8'h00;
  wire [7:0] gap_next = issued ? 8'(ddr_init_pkg::DLL_READ_GAP_CYC) : (read_ok ? 8'h00 : gap_reg - 8'h01);
  // Request bits are strobes; only the settings persist
  wire [4:0] ctrl_wr_word = (5'(wdata[ddr_init_pkg::CTRL_DRIVE_BIT]) << ddr_init_pkg::CTRL_DRIVE_BIT) |
                            (5'(wdata[ddr_init_pkg::CTRL_FINAL_LMR_BIT]) << ddr_init_pkg::CTRL_FINAL_LMR_BIT);
  wire cmd_live = !cmd_reg.cmd[3] && cmd_reg.cmd != ddr_init_pkg::CMD_NOP;
  wire dll_load_now = cmd_reg.cmd == ddr_init_pkg::CMD_LMR && cmd_reg.addr[ddr_init_pkg::DLL_RESET_BIT];
  wire [12:0] emr_word = 13'(ctrl_reg[ddr_init_pkg::CTRL_DRIVE_BIT]) << ddr_init_pkg::OUTPUT_DRIVE_STRENGTH_BIT;
  wire [12:0] mr_rst_word = mode_reg | (13'h0001 << ddr_init_pkg::DLL_RESET_BIT);
  wire [12:0] mr_run_word = mode_reg & ~(13'h0001 << ddr_init_pkg::DLL_RESET_BIT);
  wire [31:0] status_word = {29'h0, state_reg != ddr_init_pkg::ST_READY && state_reg != ddr_init_pkg::ST_IDLE,
                             read_ok, done_reg};
  wire [31:0] rd_mux = addr == ddr_init_pkg::ADDR_CTRL ? {27'h0, ctrl_reg} :
                       addr == ddr_init_pkg::ADDR_STATUS ? status_word :
                       addr == ddr_init_pkg::ADDR_MODE ? {19'h0, mode_reg} : 32'h0;

  function automatic ddr_init_pkg::ddr_cmd_t mk(input logic [3:0] c, input logic [12:0] a, input logic [1:0] b);
    ddr_init_pkg::ddr_cmd_t r;
    r.cmd = c;
    r.addr = a;
    r.bank = b;
    return r;
  endfunction

  // Every step issues at most one command then idles with no-operations for its wait
  always_comb begin
    state_next = state_reg;
    wait_next = waiting ? wait_reg - 1'b1 : wait_reg;
    cmd_next = mk(ddr_init_pkg::CMD_NOP, 13'h0, 2'b00); // R15
    issued = 1'b0;
    if (!waiting) begin
      case (state_reg)
        ddr_init_pkg::ST_IDLE: begin
          cmd_next = mk(ddr_init_pkg::CMD_DESEL, 13'h0, 2'b00);
          if (start_req) begin
            state_next = ddr_init_pkg::ST_LOCK;
            wait_next = CNT_W'(PLL_LOCK_CYCLES); // R14
          end
        end
        ddr_init_pkg::ST_LOCK: begin
          state_next = ddr_init_pkg::ST_POWERUP;
          wait_next = CNT_W'(POWERUP_CYCLES); // R01
        end
        ddr_init_pkg::ST_POWERUP: state_next = ddr_init_pkg::ST_NOP1; // R02
        ddr_init_pkg::ST_NOP1: begin
          cmd_next = mk(ddr_init_pkg::CMD_PRECHARGE, 13'h1 << ddr_init_pkg::PRECHARGE_ALL_ADDR_BIT, 2'b00); // R03
          state_next = ddr_init_pkg::ST_PRE1;
          wait_next = CNT_W'(ddr_init_pkg::TRP_CYC);
        end
        ddr_init_pkg::ST_PRE1: begin
          cmd_next = mk(ddr_init_pkg::CMD_LMR, emr_word, 2'b01); // R04
          state_next = ddr_init_pkg::ST_EMR;
          wait_next = CNT_W'(ddr_init_pkg::TMRD_CYC); // R05
        end
        ddr_init_pkg::ST_EMR: begin
          cmd_next = mk(ddr_init_pkg::CMD_LMR, mr_rst_word, 2'b00); // R06
          issued = 1'b1; // R07
          state_next = ddr_init_pkg::ST_MR1;
          wait_next = CNT_W'(ddr_init_pkg::TMRD_CYC); // R05
        end
        ddr_init_pkg::ST_MR1: begin
          cmd_next = mk(ddr_init_pkg::CMD_PRECHARGE, 13'h1 << ddr_init_pkg::PRECHARGE_ALL_ADDR_BIT, 2'b00); // R08
          state_next = ddr_init_pkg::ST_PRE2;
          wait_next = CNT_W'(ddr_init_pkg::TRP_CYC);
        end
        ddr_init_pkg::ST_PRE2: begin
          cmd_next = mk(ddr_init_pkg::CMD_REFRESH, 13'h0, 2'b00); // R09
          state_next = ddr_init_pkg::ST_REF1;
          wait_next = CNT_W'(ddr_init_pkg::TRFC_CYC);
        end
        ddr_init_pkg::ST_REF1: begin
          cmd_next = mk(ddr_init_pkg::CMD_REFRESH, 13'h0, 2'b00); // R09
          state_next = ddr_init_pkg::ST_REF2;
          wait_next = CNT_W'(ddr_init_pkg::TRFC_CYC);
        end
        ddr_init_pkg::ST_REF2: begin
          state_next = ddr_init_pkg::ST_READY;
          if (ctrl_reg[ddr_init_pkg::CTRL_FINAL_LMR_BIT]) begin
            cmd_next = mk(ddr_init_pkg::CMD_LMR, mr_run_word, 2'b00); // R10
            state_next = ddr_init_pkg::ST_MR2;
            wait_next = CNT_W'(ddr_init_pkg::TMRD_CYC);
          end
        end
        ddr_init_pkg::ST_MR2: state_next = ddr_init_pkg::ST_READY;
        ddr_init_pkg::ST_READY: begin
          // Ready; software may refresh or reset the DLL after a clock change
          if (dll_req) begin
            cmd_next = mk(ddr_init_pkg::CMD_LMR, mr_rst_word, 2'b00); // R13
            issued = 1'b1;
            state_next = ddr_init_pkg::ST_DLLRST;
            wait_next = CNT_W'(ddr_init_pkg::TMRD_CYC);
          end else if (wr_ctrl && wdata[ddr_init_pkg::CTRL_REFRESH_BIT]) begin
            cmd_next = mk(ddr_init_pkg::CMD_REFRESH, 13'h0, 2'b00);
            state_next = ddr_init_pkg::ST_MR2;
            wait_next = CNT_W'(ddr_init_pkg::TRFC_CYC);
          end
        end
        ddr_init_pkg::ST_DLLRST: state_next = ddr_init_pkg::ST_READY;
        default: state_next = ddr_init_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ddr_init_pkg::ST_IDLE;
      wait_reg <= '0;
      cmd_reg <= mk(ddr_init_pkg::CMD_DESEL, 13'h0, 2'b00);
      cke_reg <= 1'b0;
      done_reg <= 1'b0;
      gap_reg <= 8'(ddr_init_pkg::DLL_READ_GAP_CYC);
      allow_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      cmd_reg <= cmd_next;
      // Low through lock and power-up wait; never drops again, covering refresh
      if (state_reg == ddr_init_pkg::ST_POWERUP && !waiting) cke_reg <= 1'b1; // R02 R12
      done_reg <= state_next == ddr_init_pkg::ST_READY; // R11 R15
      gap_reg <= gap_next; // R07 R13
      // Built from next values so the pin moves with done, not a cycle behind
      allow_reg <= state_next == ddr_init_pkg::ST_READY && gap_next == 8'h00; // R07 R13
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg <= 5'h00;
      mode_reg <= ddr_init_pkg::MODE_RESET;
      rdata_reg <= 32'h0;
    end else begin
      if (wr_ctrl) ctrl_reg <= ctrl_wr_word;
      if (wr_mode) mode_reg <= wdata[12:0];
      rdata_reg <= rd ? rd_mux : 32'h0;
    end
  end

  assign rdata = rdata_reg;
  assign cke = cke_reg;
  assign ddr_cmd = cmd_reg;
  assign init_done = done_reg;
  assign read_allowed = allow_reg;

  // Checker state only; none of it steers the sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      hold_cnt_reg <= '0;
      since_dll_reg <= 8'h00;
      cmd_count_reg <= 4'h0;
    end else begin
      if (state_reg == ddr_init_pkg::ST_IDLE) hold_cnt_reg <= '0;
      else if (!cke_reg && hold_cnt_reg != '1) hold_cnt_reg <= hold_cnt_reg + 1'b1;
      if (dll_load_now) since_dll_reg <= 8'h01;
      else if (since_dll_reg != 8'hFF) since_dll_reg <= since_dll_reg + 8'h01;
      if (state_reg == ddr_init_pkg::ST_IDLE) cmd_count_reg <= 4'h0;
      else if (cmd_live && cmd_count_reg != 4'hF) cmd_count_reg <= cmd_count_reg + 4'h1;
    end
  end

  sequence s_lmr_dll;
    cmd_reg.cmd == ddr_init_pkg::CMD_LMR && cmd_reg.addr[ddr_init_pkg::DLL_RESET_BIT];
  endsequence

  AST_CKE_LOW_AT_START: assert property (@(posedge clk) disable iff (reset) // R01
    $rose(cke_reg) |-> $past(state_reg) == ddr_init_pkg::ST_POWERUP) else $error("cke rose early");
  AST_NOP_AFTER_CKE: assert property (@(posedge clk) disable iff (reset) // R02
    $rose(cke_reg) |-> cmd_reg.cmd == ddr_init_pkg::CMD_NOP) else $error("no nop after cke");
  AST_PRE_GAP: assert property (@(posedge clk) disable iff (reset) // R03
    cmd_reg.cmd == ddr_init_pkg::CMD_PRECHARGE |=> cmd_reg.cmd == ddr_init_pkg::CMD_NOP) else $error("trp violated");
  AST_EMR_WORD: assert property (@(posedge clk) disable iff (reset) // R04
    cmd_reg.cmd == ddr_init_pkg::CMD_LMR && cmd_reg.bank == 2'b01 |-> cmd_reg.addr[12:2] == 11'h0
    && !cmd_reg.addr[ddr_init_pkg::DLL_DISABLE_BIT]) else $error("bad emr");
  AST_MRD_GAP: assert property (@(posedge clk) disable iff (reset) // R05
    cmd_reg.cmd == ddr_init_pkg::CMD_LMR |=> cmd_reg.cmd == ddr_init_pkg::CMD_NOP) else $error("tmrd violated");
  AST_READ_GAP: assert property (@(posedge clk) disable iff (reset) // R07
    s_lmr_dll |-> !read_allowed [*8]) else $error("read allowed too soon");
  AST_REF_GAP: assert property (@(posedge clk) disable iff (reset) // R09
    cmd_reg.cmd == ddr_init_pkg::CMD_REFRESH |=> cmd_reg.cmd == ddr_init_pkg::CMD_NOP [*2]) else $error("trfc");
  AST_CKE_REFRESH: assert property (@(posedge clk) disable iff (reset) // R12
    cmd_reg.cmd == ddr_init_pkg::CMD_REFRESH |-> cke_reg [*4]) else $error("cke dropped in refresh");

  sequence s_pre_all;
    cmd_reg.cmd == ddr_init_pkg::CMD_PRECHARGE && cmd_reg.addr[ddr_init_pkg::PRECHARGE_ALL_ADDR_BIT];
  endsequence

  sequence s_emr_load;
    cmd_reg.cmd == ddr_init_pkg::CMD_LMR && cmd_reg.bank == 2'b01;
  endsequence

  sequence s_mr_load;
    cmd_reg.cmd == ddr_init_pkg::CMD_LMR && cmd_reg.bank == 2'b00;
  endsequence

  sequence s_refresh;
    cmd_reg.cmd == ddr_init_pkg::CMD_REFRESH;
  endsequence

  // Refresh wait at 40 MHz leaves three idle cycles before the next command
  sequence s_trfc_idle;
    cmd_reg.cmd == ddr_init_pkg::CMD_NOP [*3];
  endsequence

  AST_CKE_HOLD_COUNT: assert property (@(posedge clk) disable iff (reset) // R01
    $rose(cke_reg) |-> hold_cnt_reg >= CNT_W'(PLL_LOCK_CYCLES + POWERUP_CYCLES)) else $error("cke hold too short");
  AST_NOP_BEFORE_FIRST: assert property (@(posedge clk) disable iff (reset) // R02
    cmd_live && cmd_count_reg == 4'd0 |-> $past(cmd_reg.cmd) == ddr_init_pkg::CMD_NOP && $past(cke_reg))
    else $error("first command without nop");
  AST_FIRST_PRE: assert property (@(posedge clk) disable iff (reset) // R03
    cmd_live && cmd_count_reg == 4'd0 |-> s_pre_all) else $error("first command not precharge all");
  AST_EMR_SECOND: assert property (@(posedge clk) disable iff (reset) // R04
    cmd_live && cmd_count_reg == 4'd1 |-> s_emr_load) else $error("second command not emr load");
  AST_EMR_DRIVE: assert property (@(posedge clk) disable iff (reset) // R04
    s_emr_load |-> cmd_reg.addr[ddr_init_pkg::OUTPUT_DRIVE_STRENGTH_BIT] == ctrl_reg[ddr_init_pkg::CTRL_DRIVE_BIT])
    else $error("emr drive bit wrong");
  AST_MR_THIRD: assert property (@(posedge clk) disable iff (reset) // R06
    cmd_live && cmd_count_reg == 4'd2 |-> s_mr_load ##0 s_lmr_dll) else $error("third command not dll reset load");
  AST_PRE_FOURTH: assert property (@(posedge clk) disable iff (reset) // R08
    cmd_live && cmd_count_reg == 4'd3 |-> s_pre_all) else $error("fourth command not precharge all");
  AST_REF_PAIR: assert property (@(posedge clk) disable iff (reset) // R09
    cmd_live && (cmd_count_reg == 4'd4 || cmd_count_reg == 4'd5) |-> s_refresh) else $error("refresh missing");
  AST_REF_WAIT: assert property (@(posedge clk) disable iff (reset) // R09
    s_refresh |=> s_trfc_idle) else $error("refresh wait cut short");
  AST_FINAL_MR_PARAMS: assert property (@(posedge clk) disable iff (reset) // R10
    s_mr_load ##0 !cmd_reg.addr[ddr_init_pkg::DLL_RESET_BIT] |-> cmd_reg.addr == mr_run_word)
    else $error("final load changed parameters");
  AST_READ_GAP_COUNT: assert property (@(posedge clk) disable iff (reset) // R07 R13
    allow_reg |-> since_dll_reg >= 8'(ddr_init_pkg::DLL_READ_GAP_CYC)) else $error("reads allowed before dll gap");
  AST_CKE_STAYS_HIGH: assert property (@(posedge clk) disable iff (reset) // R12
    cke_reg |=> cke_reg) else $error("cke fell");
  AST_WAIT_ONLY_NOP: assert property (@(posedge clk) disable iff (reset) // R15
    waiting |=> cmd_reg.cmd == ddr_init_pkg::CMD_NOP) else $error("command inside a wait");
  AST_DONE_AFTER_SEQ: assert property (@(posedge clk) disable iff (reset) // R15
    $rose(done_reg) |-> cmd_count_reg >= 4'd6) else $error("done before full sequence");
endmodule

// ---- ddr_init_pkg.sv ----
// How it works
// [R01] Hold clock enable low with clocks running for at least 200 us.
// [R02] Raise clock enable, then send at least one no-operation first.
// [R03] Precharge all banks first, then wait row-precharge time sending no-operations.
// [R04] Load extended mode: DLL enabled, drive strength bit, higher bits zero.
// [R05] After each mode load wait mode-set delay with no-operations only.
// [R06] Then load base mode with operating parameters and DLL reset set.
// [R07] At least 200 cycles between DLL-reset mode load and any read.
// [R08] After base mode load, precharge all again and wait row-precharge time.
// [R09] Two auto refreshes, each followed by refresh cycle wait.
// [R10] Optional final base mode load clearing DLL reset, then mode-set delay.
// [R11] After full sequence the module accepts any valid command.
// [R12] Clock enable stays high throughout every auto refresh period.
// [R13] On frequency change reset the DLL, then 200 cycles before reads.
// [R14] Treat clocks stable only after the 100 ms PLL lock interval.
// [R15] Waits counted in cycles rounded up, no-operations only, done flag raised.
package ddr_init_pkg;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int POWERUP_WAIT_US = 200;
  localparam int PLL_LOCK_INTERVAL_MS = 100;
  localparam int TRP_PS = 15000;
  localparam int TMRD_PS = 10000;
  localparam int TRFC_PS = 70000;
  localparam int DLL_READ_GAP_CYC = 200;
  localparam int POWERUP_CYC = (POWERUP_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Per-millisecond count first; the interval in picoseconds would not fit an int
  localparam int PLL_LOCK_CYC = PLL_LOCK_INTERVAL_MS * ((1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int TRP_CYC = (TRP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TMRD_CYC = (TMRD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRFC_CYC = (TRFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 24;
  // Register map of the controller
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MODE = 4'h8;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DRIVE_BIT = 1;
  localparam int CTRL_FINAL_LMR_BIT = 2;
  localparam int CTRL_DLL_RESET_BIT = 3;
  localparam int CTRL_REFRESH_BIT = 4;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_READ_OK_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int DLL_DISABLE_BIT = 0;
  localparam int OUTPUT_DRIVE_STRENGTH_BIT = 1;
  localparam int DLL_RESET_BIT = 8;
  localparam logic [12:0] MODE_RESET = 13'h0032;
  // Command encoding {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_DESEL = 4'h8;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam int PRECHARGE_ALL_ADDR_BIT = 10;
  typedef struct packed {
    logic [3:0] cmd;
    logic [1:0] bank;
    logic [12:0] addr;
  } ddr_cmd_t;
  typedef enum {
    ST_IDLE, ST_LOCK, ST_POWERUP, ST_NOP1, ST_PRE1, ST_EMR, ST_MR1,
    ST_PRE2, ST_REF1, ST_REF2, ST_MR2, ST_READY, ST_DLLRST
  } init_state_t;
endpackage

// ---- ddr_module_model.sv ----
`timescale 1ns/100ps
module ddr_module_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command pins
  input wire logic cke,
  input wire ddr_init_pkg::ddr_cmd_t ddr_cmd,
  // Observation
  output logic module_ready,
  output logic [7:0] err_count,
  output logic [7:0] cmd_index,
  output logic [15:0] dll_age,
  output logic [12:0] emr_seen,
  output logic [12:0] mode_seen
);
  int gap;
  logic cke_was, nop_seen, final_seen, good, idle;
  wire logic [3:0] c = ddr_cmd.cmd;
  wire logic [12:0] a = ddr_cmd.addr;
  wire logic [1:0] b = ddr_cmd.bank;
  wire logic [7:0] i = cmd_index;
  function automatic int need(input logic [7:0] k);
    case (k)
      8'd1, 8'd4: need = ddr_init_pkg::TRP_CYC;
      8'd2, 8'd3: need = ddr_init_pkg::TMRD_CYC;
      8'd5, 8'd6: need = ddr_init_pkg::TRFC_CYC;
      default: need = 1;
    endcase
  endfunction
  assign idle = c[3] || c == ddr_init_pkg::CMD_NOP;
  assign good = (i == 8'd0 || i == 8'd3) ? (c == ddr_init_pkg::CMD_PRECHARGE && a[10]) :
    (i == 8'd1) ? (c == ddr_init_pkg::CMD_LMR && b == 2'd1 && !a[0] && a[12:2] == 11'h0) :
    (i == 8'd2) ? (c == ddr_init_pkg::CMD_LMR && b == 2'd0 && a[8]) :
    (i == 8'd4 || i == 8'd5) ? (c == ddr_init_pkg::CMD_REFRESH) :
    (i == 8'd6 && c == ddr_init_pkg::CMD_LMR) ? (b == 2'd0 && a == (mode_seen & 13'h1EFF)) : 1'b1;
  // Ready once the last wait has run out, whichever ending was taken
  assign module_ready = i >= 8'd6 && gap >= (final_seen ? ddr_init_pkg::TMRD_CYC : ddr_init_pkg::TRFC_CYC);
  always @(posedge clk) begin
    if (reset) begin
      {cmd_index, err_count, dll_age, cke_was, nop_seen, final_seen} <= '0;
      gap <= 0;
    end else begin
      cke_was <= cke;
      if (cke_was && !cke) err_count <= err_count + 8'd1;
      if (dll_age != 16'hFFFF) dll_age <= dll_age + 16'd1;
      if (idle) begin
        gap <= gap + 1;
        if (cke) nop_seen <= 1'b1;
      end else begin
        gap <= 1;
        cmd_index <= i + 8'd1;
        if (!cke || !nop_seen || gap < need(i) || !good) err_count <= err_count + 8'd1;
        if (c == ddr_init_pkg::CMD_LMR && b == 2'd0 && a[8]) dll_age <= 16'd0;
        if (i == 8'd1) emr_seen <= a;
        if (i == 8'd2) mode_seen <= a;
        if (i == 8'd6 && c == ddr_init_pkg::CMD_LMR) final_seen <= 1'b1;
      end
    end
  end
endmodule

// ---- ddr_init_ctrl_tb.sv ----
`timescale 1ns/100ps
module ddr_init_ctrl_tb;
  localparam int LOCK = 20;
  localparam int PWR = 10;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, v;
  logic cke, init_done, read_allowed, module_ready;
  ddr_init_pkg::ddr_cmd_t ddr_cmd;
  logic [7:0] err_count, cmd_index, base;
  logic [15:0] dll_age;
  logic [12:0] emr_seen, mode_seen;
  int bad_count = 0;
  int checks_done = 0;
  int n;
  always #12.5 clk = ~clk;
  ddr_init_ctrl #(.PLL_LOCK_CYCLES(LOCK), .POWERUP_CYCLES(PWR)) dut_u (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cke(cke), .ddr_cmd(ddr_cmd), .init_done(init_done),
    .read_allowed(read_allowed));
  ddr_module_model model_u (.clk(clk), .reset(reset), .cke(cke), .ddr_cmd(ddr_cmd), .module_ready(module_ready),
    .err_count(err_count), .cmd_index(cmd_index), .dll_age(dll_age), .emr_seen(emr_seen), .mode_seen(mode_seen));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    chk(32'(n < lim), 32'd1);
  endtask
  // Model registers each command one edge after it leaves the pins
  always @(posedge clk)
    if (read_allowed === 1'b1 && dll_age < 16'(ddr_init_pkg::DLL_READ_GAP_CYC - 1)) chk(32'd0, 32'd1);
  task automatic run_init(input logic [31:0] ctl, input logic [12:0] md);
    wr_reg(ddr_init_pkg::ADDR_MODE, {19'h0, md});
    wr_reg(ddr_init_pkg::ADDR_CTRL, ctl);
    wait_hi(cke, 200);
    chk(32'(n >= LOCK + PWR - 1), 32'd1);
    wait_hi(init_done, 200);
    @(posedge clk);
    #1 chk(32'(module_ready), 32'd1);
    chk(32'(cmd_index), ctl[2] ? 32'd7 : 32'd6);
    chk(32'(emr_seen), {30'h0, ctl[1], 1'b0});
    chk(32'(mode_seen), {19'h0, md | 13'h0100});
    rd_reg(ddr_init_pkg::ADDR_STATUS, v);
    chk(v, 32'h0000_0001);
    wait_hi(read_allowed, 300);
    rd_reg(ddr_init_pkg::ADDR_STATUS, v);
    chk(v, 32'h0000_0003);
    base = cmd_index;
    wr_reg(ddr_init_pkg::ADDR_CTRL, 32'h0000_0001);
    wr_reg(ddr_init_pkg::ADDR_CTRL, 32'h0000_0010);
    repeat (6) @(posedge clk);
    #1 chk(32'(cmd_index), 32'(base) + 32'd1);
    wr_reg(ddr_init_pkg::ADDR_CTRL, 32'h0000_0008);
    repeat (4) @(posedge clk);
    #1 chk(32'(read_allowed), 32'd0);
    wait_hi(read_allowed, 300);
    chk(32'(n >= 190), 32'd1);
    chk(32'(cmd_index), 32'(base) + 32'd2);
    chk(32'(err_count), 32'd0);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd_reg(ddr_init_pkg::ADDR_MODE, v);
    chk(v, {19'h0, ddr_init_pkg::MODE_RESET});
    rd_reg(4'hC, v);
    chk(v, 32'h0000_0000);
    run_init(32'h0000_0001, 13'h0062);
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    run_init(32'h0000_0007, 13'h0022);
    print_verdict();
  end
  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule
